// *** core/fhbi_pkg.sv ***
// shared constants for the flash host bus interface block
// assumes a single clock domain; imported by fhbi_flash_bus and its test bench only
`default_nettype none
package fhbi_pkg;
  // command codes seen by the command interface
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_CONFIG_SETUP = 8'h60;
  localparam logic [7:0] CMD_CONFIG_SET = 8'h03;

  localparam int DQ_W = 16;
  localparam int STATUS_W = 8;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam int ST_READY_BIT = 7;
  localparam int ST_ERASE_ERR_BIT = 5;
  localparam int ST_PROG_ERR_BIT = 4;

  // read_config_register layout
  localparam int RCR_WAIT_POL_BIT = 10;
  localparam int RCR_ASYNC_BIT = 15;
  localparam logic [15:0] RCR_RESET = 16'h8000;

  // identifier-mode word offsets
  localparam logic [7:0] ID_MFR_OFS = 8'h00;
  localparam logic [7:0] ID_DEV_OFS = 8'h01;
  localparam logic [7:0] ID_LOCK_OFS = 8'h02;
  localparam logic [7:0] ID_RCR_OFS = 8'h05;

  // address register to dq register: memory read plus output flop
  localparam logic [1:0] READ_LATENCY = 2'h2;

  typedef enum logic [2:0] {
    MODE_ARRAY = 3'b001,
    MODE_STATUS = 3'b010,
    MODE_IDENT = 3'b100
  } fhbi_mode_t;

  typedef enum logic [3:0] {
    PEND_NONE = 4'b0001,
    PEND_PROG = 4'b0010,
    PEND_ERASE = 4'b0100,
    PEND_CONFIG = 4'b1000
  } fhbi_pend_t;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_PROGRAM = 3'b010,
    ENG_ERASE = 3'b100
  } fhbi_eng_t;
endpackage : fhbi_pkg
`default_nettype wire

// *** core/fhbi_mem_if.sv ***
// carrier between the bus logic and the array memory
// assumes both ends share ref_clk
`default_nettype none
interface fhbi_mem_if #(
  parameter int AW = 16,
  parameter int DW = 16
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_addr, output rd_data);
endinterface : fhbi_mem_if
`default_nettype wire

// *** core/fhbi_array_mem.sv ***
// flash array model: one write port, one registered read port
// assumes the controller holds wr_en for a single cycle per word
`default_nettype none
module fhbi_array_mem #(
  parameter int AW = 16,
  parameter int DW = 16
) (
  input wire logic ref_clk_i,
  fhbi_mem_if.mem port
);
  if (AW < 1 || DW < 1) begin : g_bad_size
    $error("fhbi_array_mem: bad width");
  end

  logic [DW-1:0] cells [2**AW];

  // contents are not reset: an aborted word or block stays undefined
  always_ff @(posedge ref_clk_i) begin
    if (port.wr_en) begin
      cells[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= cells[port.rd_addr];
  end
endmodule : fhbi_array_mem
`default_nettype wire

// *** core/fhbi_flash_bus.sv ***
// device-side bus interface of a parallel nor flash
// assumes all pins sampled synchronously to ref_clk_i; dq is split
// into in, out and enable, the pad ring resolves the wire
// What the document asks of this block and its host
// [RULE1] reads need chip select low, reset pin high; upper bits pick block
// [RULE2] block is chosen by decoding the upper address bits
// [RULE3] async mode: address flows while address_valid_n low, held on rise
// [RULE4] sync mode: address taken on valid clock edge or address_valid_n rise
// [RULE5] host reads: reset, write high; chip select, output enable low
// [RULE6] host writes: chip select, write low; reset, output enable high
// [RULE7] write address and data taken when write or chip select rises first
// [RULE8] output enable high floats data and wait
// [RULE9] chip select high: standby, data floated whatever output enable does
// [RULE10] running program or erase finishes even when deselected
// [RULE11] after reset: async read-array mode, status 0x80
// [RULE12] reset pin low floats outputs, stops work, ignores other controls
// [RULE13] reset during program or erase aborts it, contents left undefined
// [RULE14] host waits recovery time after reset before reads and writes
// [RULE15] host should share its processor reset with the reset pin
// [RULE16] commands use an unaddressed interface; engine runs algorithms
// [RULE17] read-array command: reads return array data on all 16 lines
// [RULE18] read-status command or program/erase: status on low 8 lines
// [RULE19] identifier command: reads return id, config, lock, protection data
// [RULE20] sync: wait asserted while data invalid; polarity from config bit
// [RULE21] wait deasserted in async reads and all write cycles
// [RULE22] reset pin low resets automation and refuses writes
// [RULE23] read mode persists until another mode command is written
// [RULE24] sync mode drives wait whenever chip select and output enable low; here write must also be high, in either mode
`default_nettype none
module fhbi_flash_bus
  import fhbi_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int BLOCK_W = 4,
  parameter int PROG_CYCLES = 16,
  parameter logic [15:0] MFR_CODE = 16'h00a5, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h005a  // arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic hw_reset_n_i,
  input wire logic chip_select_n_i,
  input wire logic output_enable_n_i,
  input wire logic write_strobe_n_i,
  input wire logic address_valid_n_i,
  input wire logic flash_clk_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic wait_o,
  output logic wait_oe_o
);
  localparam int PROG_W = $clog2(PROG_CYCLES + 1);
  localparam int WORD_W = ADDR_W - BLOCK_W;

  if (ADDR_W < 16 || BLOCK_W < 1 || BLOCK_W >= ADDR_W ||
      PROG_CYCLES < 1) begin : g_bad_param
    $error("fhbi_flash_bus: unsupported parameters");
  end

  typedef struct packed {
    fhbi_mode_t mode;
    fhbi_pend_t pend;
    fhbi_eng_t eng;
    logic [PROG_W-1:0] timer;
    logic [ADDR_W-1:0] addr;
    logic locked;
    logic [ADDR_W-1:0] wr_addr;
    logic [DQ_W-1:0] wr_data;
    logic wr_prev;
    logic fclk_prev;
    logic [STATUS_W-1:0] status;
    logic [15:0] read_config_register;
    logic [1:0] lat;
    logic [ADDR_W-1:0] eng_addr;
    logic [DQ_W-1:0] eng_data;
    logic mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [DQ_W-1:0] mem_wd;
    logic [DQ_W-1:0] dq;
    logic dq_oe;
    logic wt;
    logic wt_oe;
  } fhbi_state_t;

  fhbi_state_t st;
  fhbi_state_t next_st;

  fhbi_mem_if #(.AW(ADDR_W), .DW(DQ_W)) mem_bus ();

  fhbi_array_mem #(.AW(ADDR_W), .DW(DQ_W)) u_array (
    .ref_clk_i(ref_clk_i),
    .port(mem_bus.mem)
  );

  assign mem_bus.wr_en = st.mem_we;
  assign mem_bus.wr_addr = st.mem_wa;
  assign mem_bus.wr_data = st.mem_wd;
  assign mem_bus.rd_addr = st.addr;

  function automatic fhbi_state_t reset_state();
    fhbi_state_t r;
    r = '0;
    r.mode = MODE_ARRAY;
    r.pend = PEND_NONE;
    r.eng = ENG_IDLE;
    r.status = STATUS_RESET;
    r.read_config_register = RCR_RESET;
    return r;
  endfunction : reset_state

  function automatic logic [DQ_W-1:0] id_word(
    input logic [ADDR_W-1:0] a,
    input logic [15:0] read_config_register
  );
    logic [DQ_W-1:0] w;
    w = '0;
    case (a[7:0])
      ID_MFR_OFS: w = MFR_CODE;
      ID_DEV_OFS: w = DEV_CODE;
      ID_LOCK_OFS: w = '0; // no block is ever locked here
      ID_RCR_OFS: w = read_config_register;
      default: w = '0; // protection area reads as zero
    endcase
    return w;
  endfunction : id_word

  logic sync_mode;
  logic fclk_rise;
  logic wr_act;
  logic cmd_strobe;
  logic reading;
  logic data_valid;
  logic [7:0] cmd;

  always_comb begin
    next_st = st;
    next_st.mem_we = 1'b0;
    sync_mode = !st.read_config_register[RCR_ASYNC_BIT];
    fclk_rise = flash_clk_i && !st.fclk_prev;
    next_st.fclk_prev = flash_clk_i;

    // address latch
    if (address_valid_n_i) begin
      next_st.locked = 1'b0; // [RULE3]
    end else if (!st.locked) begin
      next_st.addr = addr_i; // [RULE3]
      if (sync_mode && fclk_rise && write_strobe_n_i &&
          !chip_select_n_i) begin
        next_st.locked = 1'b1; // [RULE4]
      end
    end
    if (next_st.addr != st.addr) begin
      next_st.lat = '0;
    end else if (st.lat != READ_LATENCY) begin
      next_st.lat = st.lat + 2'h1;
    end
    // look ahead so wait drops in the same cycle as the data word lands
    data_valid = (next_st.lat == READ_LATENCY);

    // write cycle: sample while active, act when it ends
    wr_act = !chip_select_n_i && !write_strobe_n_i && output_enable_n_i;
    next_st.wr_prev = wr_act;
    if (wr_act) begin
      next_st.wr_addr = addr_i;
      next_st.wr_data = dq_i;
    end
    cmd_strobe = st.wr_prev && !wr_act; // [RULE7]
    cmd = st.wr_data[7:0];

    // program_erase_engine; deselect does not stop it
    case (st.eng)
      ENG_PROGRAM: begin
        next_st.timer = st.timer + PROG_W'(1);
        if (st.timer == PROG_W'(PROG_CYCLES - 1)) begin
          next_st.mem_we = 1'b1;
          next_st.mem_wa = st.eng_addr;
          next_st.mem_wd = st.eng_data;
          next_st.eng = ENG_IDLE;
          next_st.status[ST_READY_BIT] = 1'b1;
        end
      end
      ENG_ERASE: begin
        // one word per cycle so an abort leaves a partial block
        next_st.mem_we = 1'b1;
        next_st.mem_wa = st.eng_addr;
        next_st.mem_wd = '1;
        next_st.eng_addr = st.eng_addr + ADDR_W'(1);
        if (&st.eng_addr[WORD_W-1:0]) begin
          next_st.eng = ENG_IDLE;
          next_st.status[ST_READY_BIT] = 1'b1;
        end
      end
      default: next_st.timer = '0; // [RULE10]
    endcase

    // command_interface, decoded from data only [RULE16]
    if (cmd_strobe) begin
      if (st.eng != ENG_IDLE) begin
        if (cmd == CMD_READ_STATUS) begin
          next_st.mode = MODE_STATUS;
        end
      end else begin
        case (st.pend)
          PEND_PROG: begin
            next_st.eng = ENG_PROGRAM;
            next_st.timer = '0;
            next_st.eng_addr = st.wr_addr;
            next_st.eng_data = st.wr_data;
            next_st.status[ST_READY_BIT] = 1'b0;
            next_st.mode = MODE_STATUS; // [RULE18]
            next_st.pend = PEND_NONE;
          end
          PEND_ERASE: begin
            if (cmd == CMD_CONFIRM) begin
              next_st.eng = ENG_ERASE;
              next_st.eng_addr = {st.wr_addr[ADDR_W-1 -: BLOCK_W],
                                  WORD_W'(0)}; // [RULE2]
              next_st.status[ST_READY_BIT] = 1'b0;
            end else begin
              next_st.status[ST_ERASE_ERR_BIT] = 1'b1;
              next_st.status[ST_PROG_ERR_BIT] = 1'b1;
            end
            next_st.mode = MODE_STATUS; // [RULE18]
            next_st.pend = PEND_NONE;
          end
          PEND_CONFIG: begin
            if (cmd == CMD_CONFIG_SET) begin
              next_st.read_config_register = st.wr_addr[15:0];
            end
            next_st.pend = PEND_NONE;
          end
          default: begin
            // other codes leave the mode alone [RULE23]
            case (cmd)
              CMD_READ_ARRAY: next_st.mode = MODE_ARRAY; // [RULE17]
              CMD_READ_STATUS: next_st.mode = MODE_STATUS; // [RULE18]
              CMD_READ_ID: next_st.mode = MODE_IDENT; // [RULE19]
              CMD_PROG_SETUP: next_st.pend = PEND_PROG;
              CMD_PROG_ALT: next_st.pend = PEND_PROG;
              CMD_ERASE_SETUP: next_st.pend = PEND_ERASE;
              CMD_CONFIG_SETUP: next_st.pend = PEND_CONFIG;
              CMD_CLEAR_STATUS: begin
                next_st.status[ST_ERASE_ERR_BIT] = 1'b0;
                next_st.status[ST_PROG_ERR_BIT] = 1'b0;
              end
              default: next_st.pend = PEND_NONE;
            endcase
          end
        endcase
      end
    end

    // output side
    reading = !chip_select_n_i && !output_enable_n_i &&
              write_strobe_n_i; // [RULE1] [RULE9]
    next_st.dq_oe = reading; // [RULE8]
    case (st.mode)
      MODE_STATUS: next_st.dq = {8'h00, st.status}; // [RULE18]
      MODE_IDENT: next_st.dq = id_word(st.addr, st.read_config_register); // [RULE19]
      default: next_st.dq = mem_bus.rd_data; // [RULE17]
    endcase
    // wait is driven in both modes but only ever asserted in sync
    next_st.wt_oe = reading; // [RULE24] [RULE8]
    if (sync_mode && !data_valid) begin
      next_st.wt = st.read_config_register[RCR_WAIT_POL_BIT]; // [RULE20]
    end else begin
      next_st.wt = !st.read_config_register[RCR_WAIT_POL_BIT]; // [RULE21]
    end

    // reset pin overrides everything, engine aborted mid-way
    if (!hw_reset_n_i) begin
      next_st = reset_state(); // [RULE12] [RULE13] [RULE22] [RULE11]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st <= reset_state(); // [RULE11]
    end else begin
      st <= next_st;
    end
  end

  assign dq_o = st.dq;
  assign dq_oe_o = st.dq_oe;
  assign wait_o = st.wt;
  assign wait_oe_o = st.wt_oe;
endmodule : fhbi_flash_bus
`default_nettype wire

// *** tb/fhbi_flash_bus_monitor.sv ***
// pin checker for fhbi_flash_bus, attached by bind
// assumes every pin is sampled on ref_clk_i
`default_nettype none
module fhbi_flash_bus_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic hw_reset_n_i,
  input wire logic chip_select_n_i,
  input wire logic output_enable_n_i,
  input wire logic write_strobe_n_i,
  input wire logic dq_oe_o,
  input wire logic wait_oe_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic rd;
  assign rd = !chip_select_n_i && !output_enable_n_i && write_strobe_n_i &&
    hw_reset_n_i;
  sequence s_read_held;
    !rd ##1 rd [*3];
  endsequence
  sequence s_quiet;
    // second edge already follows the pins sampled at release
    !dq_oe_o && !wait_oe_o ##1 dq_oe_o == $past(rd);
  endsequence
  a_read_drives:
    assert property (rd && $past(rd && rst_n_i) |=> dq_oe_o)
    else $error("read not driven");
  a_read_holds:
    assert property (s_read_held |-> dq_oe_o && wait_oe_o)
    else $error("held read not driven");
  a_oe_floats:
    assert property (output_enable_n_i |=> !dq_oe_o && !wait_oe_o)
    else $error("driven with output enable high");
  a_cs_standby: assert property (chip_select_n_i |=> !dq_oe_o)
    else $error("driven in standby");
  a_pin_reset:
    assert property (!hw_reset_n_i |=> !dq_oe_o && !wait_oe_o)
    else $error("driven in pin reset");
  a_write_float:
    assert property (!write_strobe_n_i |=> !wait_oe_o && !dq_oe_o)
    else $error("driven in write cycle");
  a_wait_pairs: assert property (dq_oe_o == wait_oe_o)
    else $error("wait drive differs from data drive");
  a_release_quiet: assert property ($rose(rst_n_i) |-> s_quiet)
    else $error("outputs driven at reset release");
endmodule : fhbi_flash_bus_monitor
bind fhbi_flash_bus fhbi_flash_bus_monitor u_mon (
  .ref_clk_i, .rst_n_i, .hw_reset_n_i, .chip_select_n_i,
  .output_enable_n_i, .write_strobe_n_i, .dq_oe_o, .wait_oe_o
);
`default_nettype wire

// *** tb/fhbi_host_model.sv ***
// host bus master model for the flash pins, one access at a time
// assumes accesses are started from one bench thread
`default_nettype none
module fhbi_host_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] bus_dq_i,
  input wire logic bus_wait_i,
  output logic hw_reset_n_o,
  output logic chip_select_n_o,
  output logic output_enable_n_o,
  output logic write_strobe_n_o,
  output logic address_valid_n_o,
  output logic flash_clk_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pin_rst_n = 1'b1;
  // a processor reset also brings the flash back to array reads
  assign hw_reset_n_o = rst_n_i && pin_rst_n;
  assign address_valid_n_o = chip_select_n_o;
  initial begin
    chip_select_n_o = 1'b1;
    output_enable_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
    flash_clk_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 16'hffff;
  end
  // bus clock stands still outside accesses
  always @(posedge ref_clk_i) begin
    flash_clk_o <= chip_select_n_o ? 1'b0 : ~flash_clk_o;
  end
  task automatic drive(input logic cs, oe, we, input logic [15:0] a, d);
    @(posedge ref_clk_i);
    chip_select_n_o <= cs;
    output_enable_n_o <= oe;
    write_strobe_n_o <= we;
    addr_o <= a;
    wdata_o <= d;
  endtask : drive
  // released data lines show the inverse, never the stale word
  task automatic write_word(input logic [15:0] a, d);
    drive(1'b0, 1'b1, 1'b0, a, d);
    drive(1'b1, 1'b1, 1'b1, a, ~d);
  endtask : write_word
  // a2 arrives after a clocked latch has closed; async reads follow it
  task automatic read_word(input logic [15:0] a, a2,
                           output logic [15:0] d, output logic w);
    drive(1'b0, 1'b0, 1'b1, a, ~wdata_o);
    repeat (2) @(posedge ref_clk_i);
    addr_o <= a2;
    repeat (4) @(posedge ref_clk_i);
    d = bus_dq_i;
    w = bus_wait_i;
    drive(1'b1, 1'b1, 1'b1, a2, ~wdata_o);
  endtask : read_word
  task automatic set_reset(input logic v);
    @(posedge ref_clk_i);
    pin_rst_n <= v;
    repeat (4) @(posedge ref_clk_i);
  endtask : set_reset
endmodule : fhbi_host_model
`default_nettype wire

// *** tb/test_fhbi_flash_bus.sv ***
// self-checking bench for fhbi_flash_bus behind a host model
// assumes design defaults apart from the identifier codes
`default_nettype none
module test_fhbi_flash_bus
  import fhbi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] MFR = 16'h0c3d; // arbitrary value
  localparam logic [15:0] DEV = 16'h0e21; // arbitrary value
  localparam int PROG = 16;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hw_n, cs_n, oe_n, we_n, adv_n, fclk, dq_oe, wt, wt_oe, wt_bus, w;
  logic [15:0] addr, wdata, dq_out, dq_bus, rd, a_addr, b_addr, a_dat, b_dat;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  assign dq_bus = dq_oe ? dq_out : wdata;
  assign wt_bus = wt_oe ? wt : ~w;
  fhbi_host_model i_host (.ref_clk_i, .rst_n_i, .bus_dq_i(dq_bus),
    .bus_wait_i(wt_bus), .hw_reset_n_o(hw_n), .chip_select_n_o(cs_n),
    .output_enable_n_o(oe_n), .write_strobe_n_o(we_n),
    .address_valid_n_o(adv_n), .flash_clk_o(fclk), .addr_o(addr),
    .wdata_o(wdata));
  fhbi_flash_bus #(.PROG_CYCLES(PROG), .MFR_CODE(MFR), .DEV_CODE(DEV))
    i_fhbi_flash_bus (.ref_clk_i, .rst_n_i, .hw_reset_n_i(hw_n),
    .chip_select_n_i(cs_n), .output_enable_n_i(oe_n),
    .write_strobe_n_i(we_n), .address_valid_n_i(adv_n), .flash_clk_i(fclk),
    .addr_i(addr), .dq_i(dq_bus), .dq_o(dq_out), .dq_oe_o(dq_oe),
    .wait_o(wt), .wait_oe_o(wt_oe));
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      print_verdict();
    end
  end
  function automatic logic [15:0] status_exp(input logic ee, pe);
    return {8'h00, 2'b10, ee, pe, 4'h0};
  endfunction : status_exp
  task automatic check(input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [15:0] a, exp);
    i_host.read_word(a, a, rd, w);
    check(rd, exp);
  endtask : rd_chk
  task automatic cmd(input logic [15:0] a, input logic [7:0] c);
    i_host.write_word(a, {8'h00, c});
  endtask : cmd
  task automatic prog(input logic [15:0] a, d, input logic [7:0] c);
    cmd(a, c);
    i_host.write_word(a, d);
  endtask : prog
  // polls status; a long erase needs several hundred reads
  task automatic wait_ready;
    rd = 16'h0000;
    for (int n = 0; n < 1000 && rd[7] !== 1'b1; n++)
      i_host.read_word(16'h0000, 16'h0000, rd, w);
  endtask : wait_ready
  initial begin
    void'($urandom(83));
    a_addr = {4'h7, 12'($urandom)};
    b_addr = {4'h5, 12'($urandom)};
    a_dat = 16'($urandom);
    b_dat = 16'($urandom);
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    prog(a_addr, a_dat, CMD_PROG_SETUP);
    wait_ready();
    check(rd, status_exp(1'b0, 1'b0));
    prog(b_addr, b_dat, CMD_PROG_ALT);
    repeat (PROG + 4) @(posedge ref_clk_i);
    rd_chk(16'h0000, status_exp(1'b0, 1'b0));
    cmd(16'h0000, CMD_READ_ARRAY);
    rd_chk(b_addr, b_dat);
    check({15'h0000, w}, 16'h0001);
    rd_chk(a_addr, a_dat);
    cmd(16'h0000, CMD_READ_ID);
    rd_chk({8'h00, ID_MFR_OFS}, MFR);
    rd_chk({8'h00, ID_DEV_OFS}, DEV);
    rd_chk({8'h00, ID_RCR_OFS}, RCR_RESET);
    cmd(a_addr, CMD_ERASE_SETUP);
    cmd(a_addr, CMD_READ_ARRAY);
    rd_chk(16'h0000, status_exp(1'b1, 1'b1));
    cmd(16'h0000, CMD_CLEAR_STATUS);
    cmd(a_addr, CMD_ERASE_SETUP);
    cmd(a_addr, CMD_CONFIRM);
    // busy engine refuses the mode change and keeps reporting status
    cmd(16'h0000, CMD_READ_ARRAY);
    rd_chk(16'h0000, 16'h0000);
    wait_ready();
    cmd(16'h0000, CMD_READ_ARRAY);
    rd_chk(a_addr, 16'hffff);
    rd_chk(b_addr, b_dat);
    i_host.read_word(a_addr, b_addr, rd, w);
    check(rd, b_dat);
    prog(a_addr, a_dat, CMD_PROG_SETUP);
    i_host.set_reset(1'b0);
    cmd(16'h0000, CMD_READ_ID);
    i_host.set_reset(1'b1);
    rd_chk(b_addr, b_dat);
    cmd(16'h0000, CMD_READ_STATUS);
    rd_chk(16'h0000, status_exp(1'b0, 1'b0));
    cmd(16'h0400, CMD_CONFIG_SETUP);
    cmd(16'h0400, CMD_CONFIG_SET);
    cmd(16'h0000, CMD_READ_ARRAY);
    rd_chk(b_addr, b_dat);
    check({15'h0000, w}, 16'h0000);
    i_host.read_word(b_addr, a_addr, rd, w);
    check(rd, b_dat);
    print_verdict();
  end
endmodule : test_fhbi_flash_bus
`default_nettype wire
